// *** core/srr_top.sv ***
/*
 Measurement control and readout registers of a humidity and temperature
 sensor: run mode, start, stop, activity status and double-buffered
 3-byte results with valid flag and CRC.
 Assumes a byte register port from the serial bus front end on the same
 clock, and two measurement front ends on the same clock that answer a
 held request with a one-cycle done pulse.
*/
`timescale 1ns/10ps
module srr_top
   import srr_pkg::*;
#(
   parameter int NUM_SENSORS = SRR_NUM_SENSORS
) (
   input wire logic CLK, // 250 MHz clock
   input wire logic ARST_N, // Asynchronous reset, active low
   input wire logic [7:0] REG_ADDR, // Register byte address
   input wire logic REG_WR, // Write strobe, one cycle
   input wire logic [7:0] REG_WDATA, // Write data
   input wire logic REG_RD, // Read strobe, one cycle
   output logic [7:0] REG_RDATA, // Read data
   output logic REG_RVALID, // Read data valid, one cycle
   output logic T_MEAS_REQ, // Temperature front end run request
   input wire logic T_MEAS_DONE, // Temperature conversion finished
   input wire logic T_MEAS_OK, // Temperature sample is valid
   input wire logic [15:0] T_MEAS_DATA, // Temperature sample, 1/64 K
   output logic H_MEAS_REQ, // Humidity front end run request
   input wire logic H_MEAS_DONE, // Humidity conversion finished
   input wire logic H_MEAS_OK, // Humidity sample is valid
   input wire logic [15:0] H_MEAS_DATA // Humidity sample, 1/512 %RH
);

   // The register map has exactly two sensor bits, so no other count can be served
   if (NUM_SENSORS != SRR_NUM_SENSORS) begin : g_bad_count
      $error("srr_top supports exactly two sensors");
   end

   logic [1:0] run_mode_reg;
   logic [1:0] busy_reg;
   logic [SRR_RESULT_W-1:0] live_reg [SRR_NUM_SENSORS];
   logic [SRR_RESULT_W-1:0] shadow_reg [SRR_NUM_SENSORS];
   logic [7:0] rdata_reg;
   logic rvalid_reg;

   logic [1:0] meas_done;
   logic [1:0] meas_ok;
   logic [SRR_DATA_W-1:0] meas_data [SRR_NUM_SENSORS];
   logic [SRR_CRC_W-1:0] meas_crc [SRR_NUM_SENSORS];

   logic wr_run;
   logic wr_launch;
   logic wr_halt;
   logic [1:0] launch_bits;
   logic [1:0] halt_bits;

   assign meas_done = {H_MEAS_DONE, T_MEAS_DONE};
   assign meas_ok = {H_MEAS_OK, T_MEAS_OK};
   assign meas_data[SRR_BIT_TEMP] = T_MEAS_DATA; // R11
   assign meas_data[SRR_BIT_HUM] = H_MEAS_DATA; // R12

   assign wr_run = REG_WR && (REG_ADDR == SRR_OFS_RUN_MODE_SELECT);
   assign wr_launch = REG_WR && (REG_ADDR == SRR_OFS_MEASUREMENT_LAUNCH);
   assign wr_halt = REG_WR && (REG_ADDR == SRR_OFS_MEASUREMENT_HALT);
   // Only bits 1:0 act; reserved upper bits are dropped
   assign launch_bits = wr_launch ? REG_WDATA[1:0] : 2'h0; // R3
   assign halt_bits = wr_halt ? REG_WDATA[1:0] : 2'h0; // R3 R4

   function automatic logic [7:0] result_byte(input logic [SRR_RESULT_W-1:0] r, input logic [1:0] idx);
      case (idx)
         2'h0: result_byte = r[7:0];
         2'h1: result_byte = r[15:8];
         2'h2: result_byte = r[23:16];
         default: result_byte = 8'h00;
      endcase
   endfunction

   function automatic logic hit_result(input logic [7:0] addr, input logic [7:0] base);
      hit_result = (addr >= base) && (addr < base + 8'(SRR_RESULT_BYTES));
   endfunction

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         run_mode_reg <= SRR_RST_RUN_MODE;
      end else if (wr_run) begin
         run_mode_reg <= REG_WDATA[1:0]; // R13
      end
   end

   genvar s;
   generate
      for (s = 0; s < SRR_NUM_SENSORS; s++) begin : g_sensor
         srr_crc7 u_crc (
            .payload({meas_ok[s], meas_data[s]}),
            .crc(meas_crc[s])
         );

         // Stop acts only on a continuous sequence; a single shot runs to completion
         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               busy_reg[s] <= SRR_RST_ACTIVITY[s]; // R5 R6
            end else if (halt_bits[s] && run_mode_reg[s]) begin
               busy_reg[s] <= 1'b0; // R1 R2
            end else if (launch_bits[s]) begin
               busy_reg[s] <= 1'b1; // R14
            end else if (busy_reg[s] && meas_done[s]) begin
               busy_reg[s] <= run_mode_reg[s]; // R13
            end
         end

         // A done that coincides with stop is still kept as the latest result
         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               live_reg[s] <= SRR_RST_RESULT; // R15
            end else if (busy_reg[s] && meas_done[s]) begin
               live_reg[s][SRR_CRC_LSB +: SRR_CRC_W] <= meas_crc[s]; // R7 R9
               live_reg[s][SRR_VALID_BIT] <= meas_ok[s]; // R10
               live_reg[s][SRR_DATA_LSB +: SRR_DATA_W] <= meas_data[s]; // R7
            end
         end
      end
   endgenerate

   // Reading the lowest byte freezes all three bytes so a later sample cannot tear them
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         shadow_reg[SRR_BIT_TEMP] <= SRR_RST_RESULT;
         shadow_reg[SRR_BIT_HUM] <= SRR_RST_RESULT;
      end else if (REG_RD) begin
         if (REG_ADDR == SRR_OFS_TEMPERATURE_RESULT) begin
            shadow_reg[SRR_BIT_TEMP] <= live_reg[SRR_BIT_TEMP]; // R8
         end
         if (REG_ADDR == SRR_OFS_HUMIDITY_RESULT) begin
            shadow_reg[SRR_BIT_HUM] <= live_reg[SRR_BIT_HUM]; // R8
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_reg <= SRR_RST_RDATA;
      end else if (REG_RD) begin
         if (REG_ADDR == SRR_OFS_RUN_MODE_SELECT) begin
            rdata_reg <= {6'h00, run_mode_reg};
         end else if (REG_ADDR == SRR_OFS_MEASUREMENT_ACTIVITY) begin
            rdata_reg <= {6'h00, busy_reg}; // R5 R6
         end else if (REG_ADDR == SRR_OFS_TEMPERATURE_RESULT) begin
            rdata_reg <= result_byte(live_reg[SRR_BIT_TEMP], 2'h0); // R8 R11
         end else if (hit_result(REG_ADDR, SRR_OFS_TEMPERATURE_RESULT)) begin
            rdata_reg <= result_byte(shadow_reg[SRR_BIT_TEMP], 2'(REG_ADDR - SRR_OFS_TEMPERATURE_RESULT));
         end else if (REG_ADDR == SRR_OFS_HUMIDITY_RESULT) begin
            rdata_reg <= result_byte(live_reg[SRR_BIT_HUM], 2'h0); // R8 R12
         end else if (hit_result(REG_ADDR, SRR_OFS_HUMIDITY_RESULT)) begin
            rdata_reg <= result_byte(shadow_reg[SRR_BIT_HUM], 2'(REG_ADDR - SRR_OFS_HUMIDITY_RESULT));
         end else begin
            // Launch and halt are write-only, unmapped bytes read zero
            rdata_reg <= 8'h00; // R4
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= REG_RD;
      end
   end

   assign REG_RDATA = rdata_reg;
   assign REG_RVALID = rvalid_reg;
   assign T_MEAS_REQ = busy_reg[SRR_BIT_TEMP];
   assign H_MEAS_REQ = busy_reg[SRR_BIT_HUM];

endmodule // srr_top

// *** common/srr_pkg.sv ***
/*
 Constants for the sensor stop, status and readout block: register
 offsets, field positions, reset values and result layout.
 Assumes a byte-wide register port driven by a serial bus front end.
*/
// Operation
// R1: Humidity stop bit ends continuous humidity sequence
// R2: Temperature stop bit ends continuous temperature sequence
// R3: Zero written to stop/start bits changes nothing
// R4: Stop register write-only, bits 7:2 reserved
// R5: Status bit 1 shows humidity measuring, resets 0
// R6: Status bit 0 shows temperature measuring, resets 0
// R7: Result: data 15:0, valid 16, CRC 23:17
// R8: All result bytes latched when lowest byte accessed
// R9: CRC covers data and valid flag together
// R10: Valid flag set only for valid measurement
// R11: Temperature data unsigned, LSB first, 1/64 K
// R12: Humidity data unsigned, LSB first, 1/512 %RH
// R13: Run-mode bits: 0 single-shot, 1 continuous
// R14: Start bits begin humidity/temperature measurement
// R15: Valid flags zero until first measurement completes
package srr_pkg;

   localparam logic [7:0] SRR_OFS_RUN_MODE_SELECT = 8'h21;
   localparam logic [7:0] SRR_OFS_MEASUREMENT_LAUNCH = 8'h22;
   localparam logic [7:0] SRR_OFS_MEASUREMENT_HALT = 8'h23;
   localparam logic [7:0] SRR_OFS_MEASUREMENT_ACTIVITY = 8'h24;
   localparam logic [7:0] SRR_OFS_TEMPERATURE_RESULT = 8'h30;
   localparam logic [7:0] SRR_OFS_HUMIDITY_RESULT = 8'h33;
   localparam int SRR_RESULT_BYTES = 3;

   // Sensor index equals its bit position in the control registers
   localparam int SRR_BIT_TEMP = 0;
   localparam int SRR_BIT_HUM = 1;
   localparam int SRR_NUM_SENSORS = 2;

   localparam int SRR_DATA_LSB = 0;
   localparam int SRR_DATA_W = 16;
   localparam int SRR_VALID_BIT = 16;
   localparam int SRR_CRC_LSB = 17;
   localparam int SRR_CRC_W = 7;
   localparam int SRR_RESULT_W = 24;
   localparam int SRR_CRC_IN_W = 17;

   localparam logic [1:0] SRR_RST_RUN_MODE = 2'h0;
   localparam logic [1:0] SRR_RST_ACTIVITY = 2'h0;
   localparam logic [23:0] SRR_RST_RESULT = 24'h000000;
   localparam logic [7:0] SRR_RST_RDATA = 8'h00;

   // Default CRC generator and seed; the readout algorithm lives outside this block
   localparam logic [6:0] SRR_CRC_POLY = 7'h09;
   localparam logic [6:0] SRR_CRC_INIT = 7'h7f;

endpackage

// *** core/srr_crc7.sv ***
/*
 Combinational 7-bit CRC over the valid flag and data word of one result.
 Assumes the caller registers the output; no state is held here.
*/
`timescale 1ns/10ps
module srr_crc7
   import srr_pkg::*;
#(
   parameter logic [6:0] POLY = SRR_CRC_POLY,
   parameter logic [6:0] INIT = SRR_CRC_INIT
) (
   input wire logic [SRR_CRC_IN_W-1:0] payload, // {valid, data}, shifted MSB first
   output logic [SRR_CRC_W-1:0] crc // Remainder
);

   function automatic logic [6:0] crc_step(input logic [6:0] c, input logic b);
      logic fb;
      fb = c[6] ^ b;
      crc_step = {c[5:0], 1'b0} ^ (fb ? POLY : 7'h00);
   endfunction

   always_comb begin
      logic [6:0] c;
      c = INIT;
      for (int i = SRR_CRC_IN_W - 1; i >= 0; i--) begin
         c = crc_step(c, payload[i]); // R9
      end
      crc = c;
   end

endmodule // srr_crc7

// *** bench/srr_top_assertions.sv ***
/* Checker on the srr_top ports. Assumes a bind from the bench top. */
`timescale 1ns/10ps
module srr_top_assertions
   import srr_pkg::*;
#(
   parameter int NUM_SENSORS = SRR_NUM_SENSORS
) (
   input wire logic CLK, // Clk
   input wire logic ARST_N, // Rst
   input wire logic [7:0] REG_ADDR, // Addr
   input wire logic REG_WR, // Wr
   input wire logic [7:0] REG_WDATA, // Wdata
   input wire logic REG_RD, // Rd
   input wire logic [7:0] REG_RDATA, // Rdata
   input wire logic REG_RVALID, // Rvalid
   input wire logic T_MEAS_REQ, // T req
   input wire logic T_MEAS_DONE, // T done
   input wire logic T_MEAS_OK, // T ok
   input wire logic [15:0] T_MEAS_DATA, // T data
   input wire logic H_MEAS_REQ, // H req
   input wire logic H_MEAS_DONE, // H done
   input wire logic H_MEAS_OK, // H ok
   input wire logic [15:0] H_MEAS_DATA // H data
);
   logic [1:0] run_reg;
   logic [1:0] go;
   logic [1:0] halt;
   assign go = (REG_WR && REG_ADDR == SRR_OFS_MEASUREMENT_LAUNCH) ? REG_WDATA[1:0] : 2'h0;
   // Halt only counts for continuous sensors, so track the run mode here
   assign halt = (REG_WR && REG_ADDR == SRR_OFS_MEASUREMENT_HALT) ? REG_WDATA[1:0] & run_reg : 2'h0;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         run_reg <= 2'h0;
      else if (REG_WR && REG_ADDR == SRR_OFS_RUN_MODE_SELECT)
         run_reg <= REG_WDATA[1:0];
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   a_read_answer: assert property (REG_RD |=> REG_RVALID) else $error("no read answer");
   a_status_read: assert property (REG_RD && REG_ADDR == SRR_OFS_MEASUREMENT_ACTIVITY |=>
      REG_RDATA == {6'h00, $past(H_MEAS_REQ), $past(T_MEAS_REQ)}) else $error("bad status");
   a_halt_zero: assert property (REG_RD && REG_ADDR == SRR_OFS_MEASUREMENT_HALT |=>
      REG_RDATA == 8'h00) else $error("halt reg read");
   a_temp_go: assert property (go[0] |=> T_MEAS_REQ) else $error("temp not started");
   a_hum_go: assert property (go[1] |=> H_MEAS_REQ) else $error("hum not started");
   a_temp_halt: assert property (halt[0] |=> !T_MEAS_REQ) else $error("temp not halted");
   a_hum_halt: assert property (halt[1] |=> !H_MEAS_REQ) else $error("hum not halted");
   a_temp_quiet: assert property (!T_MEAS_REQ && !go[0] |=> !T_MEAS_REQ) else $error("temp woke");
   a_hum_quiet: assert property (!H_MEAS_REQ && !go[1] |=> !H_MEAS_REQ) else $error("hum woke");
   a_rvalid_pulse: assert property (!REG_RD |=> !REG_RVALID) else $error("stray read answer");
   a_shot_ends: assert property (T_MEAS_REQ && T_MEAS_DONE && !run_reg[0] && !go[0] |=>
      !T_MEAS_REQ) else $error("single shot kept running");
endmodule // srr_top_assertions

// *** bench/srr_fe_model.sv ***
/* Front-end model: answers a held run request with a done pulse. Assumes the block's clock. */
`timescale 1ns/10ps
module srr_fe_model #(
   parameter int DLY = 3
) (
   input wire logic clk, // Clock
   input wire logic arst_n, // Reset, active low
   input wire logic req, // Run request
   input wire logic ok_in, // Flag to report
   input wire logic [15:0] data_in, // Sample to report
   output logic done, // Done pulse
   output logic ok, // Flag, good with done
   output logic [15:0] data // Sample, good with done
);
   int cnt;
   // Inverted outside the done cycle so a stray capture shows
   assign ok = done ? ok_in : !ok_in;
   assign data = done ? data_in : ~data_in;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 0;
         done <= 1'b0;
      end else begin
         cnt <= (req && !done) ? cnt + 1 : 0;
         done <= req && !done && cnt == DLY - 1;
      end
   end
endmodule // srr_fe_model

// *** bench/srr_top_tb_top.sv ***
/* Bench top for srr_top: a row table, then hand tests. Assumes the front-end model. */
`timescale 1ns/10ps
module srr_top_tb_top
   import srr_pkg::*;
;
   logic CLK, ARST_N, REG_WR, REG_RD, REG_RVALID, T_MEAS_REQ, T_MEAS_DONE, T_MEAS_OK;
   logic H_MEAS_REQ, H_MEAS_DONE, H_MEAS_OK, t_ok, h_ok;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
   logic [15:0] T_MEAS_DATA, H_MEAS_DATA, t_dat, h_dat;
   int err_count, samples_checked;
   typedef struct {logic [7:0] wa, wd, ra, ex;} srr_row_s;
   srr_row_s rows [10] = '{'{8'h21, 8'hff, 8'h21, 8'h03}, '{8'h21, 8'h00, 8'h21, 8'h00},
      '{8'h22, 8'h00, 8'h24, 8'h00}, '{8'h23, 8'hfc, 8'h23, 8'h00}, '{8'h30, 8'hff, 8'h30, 8'h00},
      '{8'h99, 8'h5a, 8'h32, 8'h00}, '{8'h23, 8'h00, 8'h22, 8'h00}, '{8'h99, 8'h00, 8'h99, 8'h00},
      '{8'h22, 8'h02, 8'h24, 8'h02}, '{8'h24, 8'hff, 8'h24, 8'h02}};
   srr_top u_srr_top (.CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
      .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .T_MEAS_REQ(T_MEAS_REQ),
      .T_MEAS_DONE(T_MEAS_DONE), .T_MEAS_OK(T_MEAS_OK), .T_MEAS_DATA(T_MEAS_DATA), .H_MEAS_REQ(H_MEAS_REQ),
      .H_MEAS_DONE(H_MEAS_DONE), .H_MEAS_OK(H_MEAS_OK), .H_MEAS_DATA(H_MEAS_DATA));
   srr_fe_model #(.DLY(3)) u_srr_fe_model_t (.clk(CLK), .arst_n(ARST_N), .req(T_MEAS_REQ), .ok_in(t_ok),
      .data_in(t_dat), .done(T_MEAS_DONE), .ok(T_MEAS_OK), .data(T_MEAS_DATA));
   srr_fe_model #(.DLY(40)) u_srr_fe_model_h (.clk(CLK), .arst_n(ARST_N), .req(H_MEAS_REQ), .ok_in(h_ok),
      .data_in(h_dat), .done(H_MEAS_DONE), .ok(H_MEAS_OK), .data(H_MEAS_DATA));
   function automatic logic [23:0] res(input logic v, input logic [15:0] d);
      logic [6:0] c;
      c = SRR_CRC_INIT;
      for (int i = 16; i >= 0; i--)
         c = {c[5:0], 1'b0} ^ ((c[6] ^ ((i == 16) ? v : d[i])) ? SRR_CRC_POLY : 7'h00);
      return {c, v, d};
   endfunction
   task automatic give_verdict();
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [23:0] ex, got, input logic [7:0] a);
      samples_checked++;
      if (got !== ex) begin
         err_count++;
         $display("mismatch reg %h exp %h got %h", a, ex, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [23:0] ex);
      @(posedge CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1;
      chk(ex, {16'h0, REG_RDATA}, a);
      chk(24'h000001, {23'h0, REG_RVALID}, a);
   endtask
   task automatic rres(input logic [7:0] a, input logic [23:0] ex);
      for (int i = 0; i < 3; i++)
         rd(a + 8'(i), {16'h0, ex[8*i +: 8]});
   endtask
   task automatic wait_hum();
      // Look only after an edge has passed, so a start written at this edge is already visible
      for (int n = 0; n < 300; n++) begin
         @(posedge CLK);
         #1;
         if (!H_MEAS_REQ)
            return;
      end
      err_count++;
      give_verdict();
   endtask
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   initial begin
      {ARST_N, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
      {t_ok, t_dat, h_ok, h_dat} = {1'b1, 16'h1a2b, 1'b1, 16'hb3c5};
      {err_count, samples_checked} = '0;
      repeat (20) @(posedge CLK);
      ARST_N <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         rd(rows[i].ra, {16'h0, rows[i].ex});
      end
      wr(8'h21, 8'h01);
      wr(8'h22, 8'h01);
      wr(8'h23, 8'h02);
      rd(8'h24, 24'h03);
      wait_hum();
      rres(8'h33, res(1'b1, 16'hb3c5));
      h_dat = 16'h1234;
      h_ok = 1'b0;
      wr(8'h22, 8'h02);
      wait_hum();
      rd(8'h34, 24'hb3);
      rres(8'h33, res(1'b0, 16'h1234));
      rres(8'h30, res(1'b1, 16'h1a2b));
      rd(8'h24, 24'h01);
      wr(8'h23, 8'h01);
      rd(8'h24, 24'h00);
      wr(8'h21, 8'h02);
      wr(8'h22, 8'h02);
      wr(8'h23, 8'h02);
      rd(8'h24, 24'h00);
      wr(8'h21, 8'h01);
      wr(8'h22, 8'h01);
      // Reset in mid-run with a continuous sequence going and results held
      @(posedge CLK);
      ARST_N <= 1'b0;
      repeat (2) @(posedge CLK);
      ARST_N <= 1'b1;
      rd(8'h24, 24'h00);
      rd(8'h21, 24'h00);
      rres(8'h30, 24'h000000);
      rres(8'h33, 24'h000000);
      give_verdict();
   end
endmodule // srr_top_tb_top
bind srr_top srr_top_assertions #(.NUM_SENSORS(NUM_SENSORS)) u_srr_top_assertions (.CLK(CLK), .ARST_N(ARST_N),
   .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .REG_RVALID(REG_RVALID), .T_MEAS_REQ(T_MEAS_REQ), .T_MEAS_DONE(T_MEAS_DONE), .T_MEAS_OK(T_MEAS_OK),
   .T_MEAS_DATA(T_MEAS_DATA), .H_MEAS_REQ(H_MEAS_REQ), .H_MEAS_DONE(H_MEAS_DONE), .H_MEAS_OK(H_MEAS_OK),
   .H_MEAS_DATA(H_MEAS_DATA));
